// >>> bench/pin_board.sv
`timescale 1ns/1ps
// board side of the port: resolves each pin from drivers, pulls and outside world
module pin_board (
  input wire logic clock,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pull_up,
  input wire logic [15:0] pull_down,
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_en,
  output logic [15:0] pad_in
);
  logic [15:0] wob_ff = 16'h0;
  // a floating pin wobbles so a stale level never passes for a real one
  always @(posedge clock) wob_ff <= ~wob_ff;
  always_comb foreach (pad_in[i])
    pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : wob_ff[i];
endmodule // pin_board

// >>> bench/pin_port_chk.sv
`timescale 1ns/1ps
module pin_port_chk
  import pin_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire sw_write_s pin_direction_cfg_wr,
  input wire sw_write_s pin_output_latch_wr,
  input wire sw_write_s atomic_set_clear_wr,
  input wire logic [PIN_COUNT-1:0] pad_in,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] af_out,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] af_oe,
  input wire logic [31:0] pin_direction_cfg,
  input wire logic [31:0] output_driver_type,
  input wire logic [31:0] bias_resistor_cfg,
  input wire logic [31:0] peripheral_select_low,
  input wire logic [31:0] pin_output_latch,
  input wire logic [31:0] pin_input_latch,
  input wire logic [31:0] config_freeze,
  input wire logic [PIN_COUNT-1:0] af_in,
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pull_up,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  input wire logic [PIN_COUNT-1:0] pad_analog
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic [1:0] dir0 = pin_direction_cfg[1:0];
  wire logic [1:0] bias0 = bias_resistor_cfg[1:0];
  wire logic [3:0] sel0 = peripheral_select_low[3:0];
  logic [2:0] up_ff;
  logic [2:0] nxt_up;
  // cycles since reset; the input pipe holds reset zeros until full
  always_comb nxt_up = (up_ff == 3'h4) ? up_ff : up_ff + 3'h1;
  always_ff @(posedge clock or negedge nrst) if (!nrst) up_ff <= 3'h0; else up_ff <= nxt_up;

  a_push_pull: assert property (dir0 == DIR_OUTPUT && !output_driver_type[0]
    |=> pad_oe[0] && pad_out[0] == $past(pin_output_latch[0])) else $error("push-pull pad");
  a_open_drain: assert property (dir0 == DIR_OUTPUT && output_driver_type[0]
    |=> pad_oe[0] == !$past(pin_output_latch[0])) else $error("open-drain pad");
  a_input_float: assert property (dir0 == DIR_INPUT |=> !pad_oe[0])
    else $error("input pin driven");
  a_analog_quiet: assert property (dir0 == DIR_ANALOG
    |=> pad_analog[0] && !pad_pull_up[0] && !pad_pull_down[0] && !pad_oe[0])
    else $error("analog pad");
  a_bias_pulls: assert property (dir0 != DIR_ANALOG
    |=> pad_pull_up[0] == ($past(bias0) == BIAS_UP) && pad_pull_down[0] == ($past(bias0) == BIAS_DOWN))
    else $error("bias pulls");
  a_periph_route: assert property (dir0 == DIR_PERIPH && !output_driver_type[0] && af_oe[sel0]
    |=> pad_oe[0] && pad_out[0] == $past(af_out[sel0])) else $error("peripheral route");
  a_input_sync: assert property (up_ff == 3'h4
    |-> pin_input_latch[15:0] == $past(pad_in, 3) && af_in == pin_input_latch[15:0])
    else $error("input sampling");
  a_set_clear: assert property (atomic_set_clear_wr.en && atomic_set_clear_wr.be == 4'hF
    && !pin_output_latch_wr.en |=> pin_output_latch[15:0] == (($past(pin_output_latch[15:0])
    & ~$past(atomic_set_clear_wr.data[31:16])) | $past(atomic_set_clear_wr.data[15:0])))
    else $error("set clear");
  a_reserved_zero: assert property (pin_output_latch[31:16] == 16'h0
    && output_driver_type[31:16] == 16'h0 && config_freeze[31:17] == 15'h0)
    else $error("reserved bits");
  a_frozen_dir: assert property (config_freeze[0] && pin_direction_cfg_wr.en |=> $stable(dir0))
    else $error("frozen field moved");
  c_periph: cover property (dir0 == DIR_PERIPH && pad_oe[0]);
  c_frozen: cover property (config_freeze[16]);
  c_pull: cover property (pad_pull_up[0]);
endmodule // pin_port_chk

bind pin_port pin_port_chk pin_port_chk_i (.*);

// >>> bench/pin_port_tb.sv
`timescale 1ns/1ps
module pin_port_tb;
  import pin_port_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  sw_write_s w [9];
  logic [255:0] af_out = '0;
  logic [255:0] af_oe = '0;
  logic [15:0] ext_val = 16'h0;
  logic [15:0] ext_en = 16'h0;
  logic [15:0] pad_in, af_in, pad_out, pad_oe, pup, pdn, pana;
  logic [31:0] rb [9];
  logic [31:0] spd;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 clock = ~clock;

  pin_port pin_port_i (.clock(clock), .nrst(nrst), .pin_direction_cfg_wr(w[0]),
    .output_driver_type_wr(w[1]), .slew_rate_cfg_wr(w[2]), .bias_resistor_cfg_wr(w[3]),
    .peripheral_select_low_wr(w[4]), .peripheral_select_high_wr(w[5]),
    .pin_output_latch_wr(w[6]), .atomic_set_clear_wr(w[7]), .config_freeze_wr(w[8]),
    .pad_in(pad_in), .af_out(af_out), .af_oe(af_oe), .pin_direction_cfg(rb[0]),
    .output_driver_type(rb[1]), .slew_rate_cfg(rb[2]), .bias_resistor_cfg(rb[3]),
    .peripheral_select_low(rb[4]), .peripheral_select_high(rb[5]),
    .pin_output_latch(rb[6]), .pin_input_latch(rb[7]), .config_freeze(rb[8]),
    .af_in(af_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pup),
    .pad_pull_down(pdn), .pad_analog(pana), .pad_speed(spd));
  pin_board pin_board_i (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pup),
    .pull_down(pdn), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write pulse then one idle cycle, so repeated writes never retime en in one step
  task automatic wr(input int r, input logic [31:0] d, input logic [3:0] be = 4'hF);
    w[r] = '{1'b1, be, d};
    @(negedge clock);
    w[r].en = 1'b0;
    @(negedge clock);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_modes();
    wr(6, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(0, m);
      tick(1);
      chk(pad_oe[0], m == 1);
      chk(pana[0], m == 3);
    end
    wr(0, 32'hFFFF_FF05, 4'h1);
    chk(rb[0], 32'h5);
    wr(0, 32'hAAAA_AAAA, 4'hC);
    chk(rb[0], 32'hAAAA_0005);
    wr(2, 32'h0000_0002);
    chk(rb[2], 32'h2);
    chk(spd[1:0], 2'h2);
  endtask
  task automatic t_drive();
    wr(0, 32'h1);
    wr(1, 32'hFFFF_0001);
    chk(rb[1], 32'h1);
    wr(6, 32'h0);
    tick(1);
    chk({pad_oe[0], pad_in[0]}, 2'h2);
    wr(6, 32'h1);
    for (int b = 1; b < 3; b++) begin
      wr(3, b);
      tick(3);
      chk({pup[0], pdn[0], rb[7][0]}, b == 1 ? 3'h5 : 3'h2);
    end
    wr(1, 32'h0);
    // back-to-back latch writes toggle the pin every cycle
    w[6] = '{1'b1, 4'hF, 32'h1};
    @(negedge clock);
    w[6].data = 32'h0;
    @(negedge clock);
    chk(pad_out[0], 1'b1);
    w[6].en = 1'b0;
    @(negedge clock);
    chk(pad_out[0], 1'b0);
  endtask
  task automatic t_setclr();
    wr(6, 32'h00FF);
    wr(7, 32'h0003_0101);
    chk(rb[6], 32'h01FD);
    w[6] = '{1'b1, 4'hF, 32'h0};
    w[7] = '{1'b1, 4'hF, 32'h0000_0002};
    @(negedge clock);
    w[6].en = 1'b0;
    w[7].en = 1'b0;
    chk(rb[6], 32'h2);
  endtask
  task automatic t_periph();
    wr(0, 32'h2);
    wr(4, 32'h5);
    af_out[5] = 1'b1;
    af_oe[5] = 1'b1;
    tick(1);
    chk({pad_oe[0], pad_out[0]}, 2'h3);
    af_out[5] = 1'b0;
    tick(1);
    chk(pad_out[0], 1'b0);
    wr(5, 32'hF000_0003);
    chk(rb[5], 32'hF000_0003);
  endtask
  task automatic t_input();
    wr(0, 32'h0);
    wr(3, 32'h0);
    ext_en = 16'hFFFF;
    tick(4);
    ext_val = 16'hA5C3;
    tick(2);
    chk(rb[7], 32'h0);
    tick(1);
    chk(rb[7], 32'hA5C3);
    chk(af_in, 16'hA5C3);
  endtask
  task automatic t_freeze();
    wr(0, 32'h5);
    wr(8, 32'h0001_0001);
    wr(8, 32'h0000_0001);
    wr(8, 32'h0001_0001);
    tick(1);
    chk(rb[8], 32'h0001_0001);
    wr(0, 32'hF);
    chk(rb[0], 32'hD);
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    chk(rb[8], 32'h0);
    wr(0, 32'hF);
    chk(rb[0], 32'hF);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    foreach (w[i]) w[i] = '0;
    tick(2);
    nrst = 1'b1;
    foreach (rb[i]) chk(rb[i], 32'h0);
    chk(pad_oe, 16'h0);
    t_modes();
    t_drive();
    t_setclr();
    t_periph();
    t_input();
    t_freeze();
    test_done();
  end
endmodule // pin_port_tb

// >>> verilog/lock_seq.sv
`timescale 1ns/1ps
module lock_seq
  import pin_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire sw_write_s wr,
  output logic [PIN_COUNT-1:0] frozen,
  output logic key_active
);

  // ***********************************************************
  // freeze key sequence: write 1, write 0, write 1 with same mask
  // ***********************************************************
  lock_state_e state_ff;
  lock_state_e nxt_state;
  logic [PIN_COUNT-1:0] mask_ff;
  logic [PIN_COUNT-1:0] nxt_mask;
  logic [PIN_COUNT-1:0] frozen_ff;
  logic [PIN_COUNT-1:0] nxt_frozen;
  logic full;
  logic key;
  logic key_ff;
  logic nxt_key;

  // only a full word write carries key and mask together
  always_comb begin
    full = wr.en && (wr.be == 4'hF);
    key = wr.data[LOCK_KEY_BIT];
    nxt_state = state_ff;
    nxt_mask = mask_ff;
    nxt_frozen = frozen_ff;
    case (state_ff)
      LK_IDLE: begin
        if (full && key) begin
          nxt_state = LK_ONE;
          nxt_mask = wr.data[PIN_COUNT-1:0];
        end
      end
      LK_ONE: begin
        if (full) begin
          nxt_state = (!key && wr.data[PIN_COUNT-1:0] == mask_ff) ? LK_ZERO : LK_IDLE;
        end
      end
      LK_ZERO: begin
        if (full) begin
          if (key && wr.data[PIN_COUNT-1:0] == mask_ff) begin
            nxt_state = LK_ARMED;
            nxt_frozen = frozen_ff | mask_ff;
          end else begin
            nxt_state = LK_IDLE;
          end
        end
      end
      LK_ARMED: begin
        nxt_state = LK_ARMED; // sticky until reset
      end
      default: nxt_state = LK_IDLE;
    endcase
    nxt_key = (nxt_state == LK_ARMED);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= LK_IDLE;
      mask_ff <= '0;
      frozen_ff <= '0;
      key_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mask_ff <= nxt_mask;
      frozen_ff <= nxt_frozen;
      key_ff <= nxt_key;
    end
  end

  assign frozen = frozen_ff;
  // registered so the status bit leaves a flop like every other output
  assign key_active = key_ff;

endmodule // lock_seq

// >>> verilog/pin_port.sv
`timescale 1ns/1ps
module pin_port
  import pin_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire sw_write_s pin_direction_cfg_wr,
  input wire sw_write_s output_driver_type_wr,
  input wire sw_write_s slew_rate_cfg_wr,
  input wire sw_write_s bias_resistor_cfg_wr,
  input wire sw_write_s peripheral_select_low_wr,
  input wire sw_write_s peripheral_select_high_wr,
  input wire sw_write_s pin_output_latch_wr,
  input wire sw_write_s atomic_set_clear_wr,
  input wire sw_write_s config_freeze_wr,
  input wire logic [PIN_COUNT-1:0] pad_in,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] af_out,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] af_oe,
  output logic [31:0] pin_direction_cfg,
  output logic [31:0] output_driver_type,
  output logic [31:0] slew_rate_cfg,
  output logic [31:0] bias_resistor_cfg,
  output logic [31:0] peripheral_select_low,
  output logic [31:0] peripheral_select_high,
  output logic [31:0] pin_output_latch,
  output logic [31:0] pin_input_latch,
  output logic [31:0] config_freeze,
  output logic [PIN_COUNT-1:0] af_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pull_up,
  output logic [PIN_COUNT-1:0] pad_pull_down,
  output logic [PIN_COUNT-1:0] pad_analog,
  output logic [2*PIN_COUNT-1:0] pad_speed
);

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  // direction, two bits per pin
  logic [31:0] dir_ff;
  logic [31:0] nxt_dir;
  // driver type, one bit per pin
  logic [15:0] type_ff;
  logic [15:0] nxt_type;
  // speed, two bits per pin
  logic [31:0] speed_ff;
  logic [31:0] nxt_speed;
  // bias, two bits per pin
  logic [31:0] bias_ff;
  logic [31:0] nxt_bias;
  // peripheral selects, four bits per pin
  logic [31:0] sel_lo_ff;
  logic [31:0] nxt_sel_lo;
  logic [31:0] sel_hi_ff;
  logic [31:0] nxt_sel_hi;
  // output latch
  logic [15:0] out_ff;
  logic [15:0] nxt_out;

  // from the freeze sequencer
  logic [PIN_COUNT-1:0] frozen;
  logic key_active;

  // ***********************************************************
  // write helpers
  // ***********************************************************
  // byte-lane merge, skipping bits of frozen pins; a lane with its enable low
  // keeps its old bits, so byte and half-word writes never disturb neighbours
  function automatic logic [31:0] merge(input logic [31:0] old, input sw_write_s wr,
                                        input logic [31:0] keep);
    logic [31:0] lane;
    lane = {{8{wr.be[3]}}, {8{wr.be[2]}}, {8{wr.be[1]}}, {8{wr.be[0]}}};
    merge = old;
    if (wr.en) begin
      merge = (old & (~lane | keep)) | (wr.data & lane & ~keep);
    end
  endfunction

  // widen a per-pin freeze mask to 2-bit and 4-bit fields
  // so a frozen pin masks every bit of its own field and nothing else
  function automatic logic [31:0] spread2(input logic [15:0] m);
    spread2 = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      spread2[2*i +: 2] = {2{m[i]}};
    end
  endfunction

  // four-bit select fields cover eight pins per register
  function automatic logic [31:0] spread4(input logic [7:0] m);
    spread4 = '0;
    for (int i = 0; i < 8; i++) begin
      spread4[4*i +: 4] = {4{m[i]}};
    end
  endfunction

  // next config values; a frozen pin keeps every field
  // the type register has only sixteen live bits, so its upper lanes are masked
  always_comb begin
    logic [31:0] tnew;
    tnew = merge({16'h0000, type_ff}, output_driver_type_wr, {16'hFFFF, frozen});
    nxt_type = tnew[15:0];
    nxt_dir = merge(dir_ff, pin_direction_cfg_wr, spread2(frozen));
    nxt_speed = merge(speed_ff, slew_rate_cfg_wr, spread2(frozen));
    nxt_bias = merge(bias_ff, bias_resistor_cfg_wr, spread2(frozen));
    nxt_sel_lo = merge(sel_lo_ff, peripheral_select_low_wr, spread4(frozen[7:0]));
    nxt_sel_hi = merge(sel_hi_ff, peripheral_select_high_wr, spread4(frozen[15:8]));
  end

  // reset: all inputs, no bias, peripheral 0
  // selects reset too although input pins ignore them
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dir_ff <= RST_DIR;
      type_ff <= RST_TYPE;
      speed_ff <= RST_SPEED;
      bias_ff <= RST_BIAS;
      sel_lo_ff <= RST_SEL;
      sel_hi_ff <= RST_SEL;
    end else begin
      dir_ff <= nxt_dir;
      type_ff <= nxt_type;
      speed_ff <= nxt_speed;
      bias_ff <= nxt_bias;
      sel_lo_ff <= nxt_sel_lo;
      sel_hi_ff <= nxt_sel_hi;
    end
  end

  // ***********************************************************
  // output latch with atomic set/clear
  // ***********************************************************
  // direct write first, then clear, then set so set wins
  // set applied last: a set and a clear of one bit in one write leaves it set
  // a direct latch write and a set/clear in one cycle merge rather than drop
  always_comb begin
    logic [31:0] onew;
    logic [15:0] set_m;
    logic [15:0] clr_m;
    onew = merge({16'h0000, out_ff}, pin_output_latch_wr, 32'hFFFF_0000);
    set_m = '0;
    clr_m = '0;
    // lanes not enabled contribute neither set nor clear bits
    if (atomic_set_clear_wr.en) begin
      set_m = atomic_set_clear_wr.data[15:0] &
              {{8{atomic_set_clear_wr.be[1]}}, {8{atomic_set_clear_wr.be[0]}}};
      clr_m = atomic_set_clear_wr.data[31:16] &
              {{8{atomic_set_clear_wr.be[3]}}, {8{atomic_set_clear_wr.be[2]}}};
    end
    nxt_out = (onew[15:0] & ~clr_m) | set_m;
  end

  // one write per cycle lands next edge, so toggling every cycle works
  // no enable: the latch register updates on every edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_ff <= RST_OUT;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // ***********************************************************
  // lock sequencer
  // ***********************************************************
  // the sequencer owns the freeze mask; the fields above only read it
  // a partial write never advances the key, so byte stores cannot arm it
  lock_seq u_lock (
    .clock(clock),
    .nrst(nrst),
    .wr(config_freeze_wr),
    .frozen(frozen),
    .key_active(key_active)
  );

  // ***********************************************************
  // input sampling: two-flop synchroniser, then the latch
  // ***********************************************************
  logic [PIN_COUNT-1:0] sync1_ff;
  logic [PIN_COUNT-1:0] sync2_ff;
  logic [PIN_COUNT-1:0] nxt_in;
  logic [PIN_COUNT-1:0] in_ff;

  // the latch takes every cycle; no enable, the level is always fresh
  always_comb begin
    nxt_in = sync2_ff;
  end

  // pads are asynchronous; first stage read only by the second
  // cost: a pin change reaches the latch three edges later
  // reset clears the pipe, so the latch reads zero until three edges pass
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      in_ff <= '0;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      in_ff <= nxt_in;
    end
  end

  // ***********************************************************
  // per-pin driver decode
  // ***********************************************************
  pad_ctrl_s pad_c [PIN_COUNT];
  pad_ctrl_s pad_ff [PIN_COUNT];

  // low pins take their select from the low register, high pins from the high one
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pin_cfg_s cfg;
    // one assignment fills the whole field bundle for this pin
    assign cfg = '{
      dir: dir_ff[2*g +: 2],
      drv_type: type_ff[g],
      speed: speed_ff[2*g +: 2],
      bias: bias_ff[2*g +: 2],
      af_sel: (g < 8) ? sel_lo_ff[4*(g%8) +: 4] : sel_hi_ff[4*(g%8) +: 4]
    };
    // the slice is pure decode; all state stays in this module
    pin_slice u_slice (
      .cfg(cfg),
      .latch_bit(out_ff[g]),
      .af_out(af_out[AF_COUNT*g +: AF_COUNT]),
      .af_oe(af_oe[AF_COUNT*g +: AF_COUNT]),
      .pad(pad_c[g])
    );
  end

  // pad controls are registered so every output leaves a flop
  // the price: a write shows on the pads one edge after its read-back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        pad_ff[i] <= '0; // floating input at reset
      end
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        pad_ff[i] <= pad_c[i];
      end
    end
  end

  // ***********************************************************
  // pin outputs
  // ***********************************************************
  // unpack the registered pad bundles onto flat pin buses
  // pad_speed follows the field whatever the direction
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pad_out[i] = pad_ff[i].out_val;
      pad_oe[i] = pad_ff[i].out_en;
      pad_pull_up[i] = pad_ff[i].pull_up;
      pad_pull_down[i] = pad_ff[i].pull_down;
      pad_analog[i] = pad_ff[i].analog;
      pad_speed[2*i +: 2] = pad_ff[i].speed;
    end
  end

  // ***********************************************************
  // read-back
  // ***********************************************************
  // configuration read-back straight from the field flops
  assign pin_direction_cfg = dir_ff;
  assign slew_rate_cfg = speed_ff;
  assign bias_resistor_cfg = bias_ff;
  assign peripheral_select_low = sel_lo_ff;
  assign peripheral_select_high = sel_hi_ff;

  // unused upper halves read as zero
  assign output_driver_type = {16'h0000, type_ff};
  assign pin_output_latch = {16'h0000, out_ff};
  assign pin_input_latch = {16'h0000, in_ff};

  // freeze status: key flag above the per-pin mask
  assign config_freeze = {15'h0000, key_active, frozen};

  // peripherals see the same synchronised levels as the input latch
  assign af_in = in_ff;

endmodule // pin_port

// >>> verilog/pin_port_pkg.sv
package pin_port_pkg;

  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int PIN_COUNT = 16;
  localparam int AF_COUNT = 16;
  localparam int AF_SEL_W = 4;
  localparam int LOCK_KEY_BIT = 16;

  // ***********************************************************
  // field encodings
  // ***********************************************************
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_OUTPUT = 2'h1;
  localparam logic [1:0] DIR_PERIPH = 2'h2;
  localparam logic [1:0] DIR_ANALOG = 2'h3;
  localparam logic TYPE_TOTEM = 1'h0;
  localparam logic TYPE_OPEN_DRAIN = 1'h1;
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_UP = 2'h1;
  localparam logic [1:0] BIAS_DOWN = 2'h2;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [15:0] RST_TYPE = 16'h0000;
  localparam logic [31:0] RST_SPEED = 32'h0000_0000;
  localparam logic [31:0] RST_BIAS = 32'h0000_0000;
  localparam logic [31:0] RST_SEL = 32'h0000_0000;
  localparam logic [15:0] RST_OUT = 16'h0000;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic [1:0] dir;
    logic drv_type;
    logic [1:0] speed;
    logic [1:0] bias;
    logic [3:0] af_sel;
  } pin_cfg_s;

  // one software write: data with per-byte enables
  typedef struct packed {
    logic en;
    logic [3:0] be;
    logic [31:0] data;
  } sw_write_s;

  // what one pin's driver sees
  typedef struct packed {
    logic out_val;
    logic out_en;
    logic pull_up;
    logic pull_down;
    logic analog;
    logic [1:0] speed;
  } pad_ctrl_s;

  typedef enum logic [1:0] {LK_IDLE, LK_ONE, LK_ZERO, LK_ARMED} lock_state_e;

endpackage

// >>> verilog/pin_slice.sv
`timescale 1ns/1ps
module pin_slice
  import pin_port_pkg::*;
(
  input wire pin_cfg_s cfg,
  input wire logic latch_bit,
  input wire logic [AF_COUNT-1:0] af_out,
  input wire logic [AF_COUNT-1:0] af_oe,
  output pad_ctrl_s pad
);

  // ***********************************************************
  // per-pin driver decode
  // ***********************************************************
  logic src_val;
  logic src_en;
  logic driving;
  logic bias_ok;

  // source: latch or the peripheral chosen by af_sel
  always_comb begin
    src_val = latch_bit;
    src_en = 1'b1;
    if (cfg.dir == DIR_PERIPH) begin
      src_val = af_out[cfg.af_sel];
      src_en = af_oe[cfg.af_sel];
    end
    driving = (cfg.dir == DIR_OUTPUT) || (cfg.dir == DIR_PERIPH);
    // open drain only pulls low, a one releases the pad
    pad.out_en = driving && src_en && ((cfg.drv_type == TYPE_TOTEM) || !src_val);
    pad.out_val = src_val;
    // analog keeps bias off; reserved code 11 acts as no pull
    bias_ok = (cfg.dir != DIR_ANALOG);
    pad.pull_up = bias_ok && (cfg.bias == BIAS_UP);
    pad.pull_down = bias_ok && (cfg.bias == BIAS_DOWN);
    pad.analog = (cfg.dir == DIR_ANALOG);
    pad.speed = cfg.speed;
  end

endmodule // pin_slice
